// [shared/ppdc_pkg.sv]
package ppdc_pkg;

   // ------------------------------------------------------------------
   // Widths and types
   // ------------------------------------------------------------------
   localparam int ADDR_W  = 4;
   localparam int DATA_W  = 16;
   localparam int NUM_CH  = 8;

   typedef logic [ADDR_W-1:0] ppdc_addr_t;
   typedef logic [DATA_W-1:0] ppdc_word_t;

   // ------------------------------------------------------------------
   // Register select codes
   // ------------------------------------------------------------------
   localparam ppdc_addr_t ADDR_POWER_REF  = 4'h0;
   localparam ppdc_addr_t ADDR_OPEN_DRAIN = 4'h1;
   localparam ppdc_addr_t ADDR_HIGH_Z     = 4'h2;
   localparam ppdc_addr_t ADDR_OUT_SELECT = 4'h3;
   localparam ppdc_addr_t ADDR_PIN_LEVEL  = 4'h4;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int GLOBAL_POWER_DOWN_BIT = 10;
   localparam int REF_ENABLE_BIT        = 9;
   localparam int SLEEP_LSB             = 0;
   localparam int PIN_LSB               = 0;

   // ------------------------------------------------------------------
   // Writable masks and reset values
   // ------------------------------------------------------------------
   localparam ppdc_word_t POWER_WMASK     = 16'h06ff;
   localparam ppdc_word_t PIN_WMASK       = 16'h00ff;
   localparam ppdc_word_t RST_POWER_REF   = 16'h0000;
   localparam ppdc_word_t RST_OPEN_DRAIN  = 16'h0000;
   localparam ppdc_word_t RST_HIGH_Z      = 16'h0000;
   localparam ppdc_word_t RST_OUT_SELECT  = 16'h0000;
   localparam ppdc_word_t READ_ZERO       = 16'h0000;

endpackage

// [rtl/ppdc_pin_drive.sv]
`timescale 1ns/1ps
module ppdc_pin_drive (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic clk_en,
   // Configuration of this pin
   input  wire logic out_select,
   input  wire logic open_drain,
   input  wire logic high_z,
   input  wire logic level,
   // Pad driver
   output logic      pin_out,
   output logic      pin_oe_n
);
   import ppdc_pkg::*;

   logic out_d;
   logic out_q;
   logic oe_n_d;
   logic oe_n_q;

   // ------------------------------------------------------------------
   // Driver decision
   // ------------------------------------------------------------------
   // Three-state wins over the output select so software can park a pin
   // without first giving up its output function.
   always_comb begin
      out_d  = 1'b0;
      oe_n_d = 1'b1;
      if (high_z) begin
         out_d  = 1'b0;
         oe_n_d = 1'b1;
      end else if (out_select) begin
         if (open_drain) begin
            out_d  = 1'b0;
            oe_n_d = level;
         end else begin
            out_d  = level;
            oe_n_d = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         out_q  <= 1'b0;
         oe_n_q <= 1'b1;
      end else if (clk_en) begin
         out_q  <= out_d;
         oe_n_q <= oe_n_d;
      end
   end

   assign pin_out  = out_q;
   assign pin_oe_n = oe_n_q;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_open_drain_release;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && out_select && !high_z && open_drain)
         |=> (pin_out == 1'b0) && (pin_oe_n == $past(level));
   endproperty
   a_open_drain_release: assert property (p_open_drain_release)
      else $error("open-drain pin not driven low-or-released");

   property p_high_z_release;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && high_z) |=> pin_oe_n;
   endproperty
   a_high_z_release: assert property (p_high_z_release)
      else $error("three-state pin still driven");

   property p_push_pull_drive;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && out_select && !high_z && !open_drain)
         |=> !pin_oe_n && (pin_out == $past(level));
   endproperty
   a_push_pull_drive: assert property (p_push_pull_drive)
      else $error("push-pull output not driving its level");

   c_open_drain_low: cover property (@(posedge ref_clk) disable iff (reset)
      out_select && open_drain && !pin_oe_n);

endmodule // ppdc_pin_drive

// [rtl/ppdc_config_regs.sv]
// How it works
// - Global power-down kills reference, DACs and ADC.
// - Otherwise reference and DACs follow own bits.
// - Reference enable powers reference, buffer, pin.
// - Reference enable clear keeps reference, buffer off.
// - Channel sleep applies only to DAC channels.
// - Open-drain bit chooses open-drain over push-pull.
// - Open-drain register resets to all zeros.
// - Three-state bit releases the pin.
// - Three-state register resets to all zeros.
// - Output select bit makes pin general output.
`timescale 1ns/1ps
module ppdc_config_regs #(
   parameter int NUM_PINS = 8
) (
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   input  wire logic                 clk_en,
   // Register access from the serial interface logic
   input  wire logic                 reg_wr_en,
   input  wire logic                 reg_rd_en,
   input  wire ppdc_pkg::ppdc_addr_t reg_addr,
   input  wire ppdc_pkg::ppdc_word_t reg_wdata,
   output ppdc_pkg::ppdc_word_t      reg_rdata,
   output logic                      reg_rd_valid,
   // Pin function state from the pin configuration logic
   input  wire logic [NUM_PINS-1:0]  dac_mode_mask,
   input  wire logic [NUM_PINS-1:0]  gpio_level,
   // Analog power controls
   output logic                      ref_power_up,
   output logic                      ref_buffer_power_up,
   output logic                      ref_pin_drive,
   output logic [NUM_PINS-1:0]       dac_power_down,
   output logic                      adc_power_down,
   // I/O pins
   input  wire logic [NUM_PINS-1:0]  pin_in,
   output logic [NUM_PINS-1:0]       pin_out,
   output logic [NUM_PINS-1:0]       pin_oe_n
);
   import ppdc_pkg::*;

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   // The register layouts hold exactly one bit per pin in the low byte.
   if (NUM_PINS != NUM_CH) begin : g_bad_pins
      $error("NUM_PINS must match the fixed register layout");
   end

   // ------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------
   ppdc_word_t power_q;
   ppdc_word_t power_d;
   ppdc_word_t open_drain_q;
   ppdc_word_t open_drain_d;
   ppdc_word_t high_z_q;
   ppdc_word_t high_z_d;
   ppdc_word_t out_sel_q;
   ppdc_word_t out_sel_d;

   // Only the writable bits are stored, so reserved bits cannot be
   // set by any write and always read back as zero.
   always_comb begin
      power_d      = power_q;
      open_drain_d = open_drain_q;
      high_z_d     = high_z_q;
      out_sel_d    = out_sel_q;
      if (reg_wr_en) begin
         unique case (reg_addr)
            ADDR_POWER_REF:
               power_d = reg_wdata & POWER_WMASK;
            ADDR_OPEN_DRAIN:
               open_drain_d = reg_wdata & PIN_WMASK;
            ADDR_HIGH_Z:
               high_z_d = reg_wdata & PIN_WMASK;
            ADDR_OUT_SELECT:
               out_sel_d = reg_wdata & PIN_WMASK;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         power_q      <= RST_POWER_REF;
         open_drain_q <= RST_OPEN_DRAIN;
         high_z_q     <= RST_HIGH_Z;
         out_sel_q    <= RST_OUT_SELECT;
      end else if (clk_en) begin
         power_q      <= power_d;
         open_drain_q <= open_drain_d;
         high_z_q     <= high_z_d;
         out_sel_q    <= out_sel_d;
      end
   end

   // ------------------------------------------------------------------
   // Pin input synchroniser
   // ------------------------------------------------------------------
   logic [NUM_PINS-1:0] pin_meta_q;
   logic [NUM_PINS-1:0] pin_sync_q;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else if (clk_en) begin
         pin_meta_q <= pin_in;
         pin_sync_q <= pin_meta_q;
      end
   end

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------
   ppdc_word_t rdata_d;
   ppdc_word_t rdata_q;
   logic       rd_valid_d;
   logic       rd_valid_q;

   // A read in the same cycle as a write returns the old contents.
   always_comb begin
      rdata_d    = rdata_q;
      rd_valid_d = 1'b0;
      if (reg_rd_en) begin
         rd_valid_d = 1'b1;
         unique case (reg_addr)
            ADDR_POWER_REF:  rdata_d = power_q;
            ADDR_OPEN_DRAIN: rdata_d = open_drain_q;
            ADDR_HIGH_Z:     rdata_d = high_z_q;
            ADDR_OUT_SELECT: rdata_d = out_sel_q;
            ADDR_PIN_LEVEL:
               rdata_d = {{(DATA_W-NUM_PINS){1'b0}}, pin_sync_q};
            default:         rdata_d = READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rdata_q    <= READ_ZERO;
         rd_valid_q <= 1'b0;
      end else if (clk_en) begin
         rdata_q    <= rdata_d;
         rd_valid_q <= rd_valid_d;
      end
   end

   assign reg_rdata    = rdata_q;
   assign reg_rd_valid = rd_valid_q;

   // ------------------------------------------------------------------
   // Power control
   // ------------------------------------------------------------------
   logic                global_down;
   logic                ref_enable;
   logic [NUM_PINS-1:0] channel_sleep;
   logic [NUM_PINS-1:0] dac_down_d;
   logic [NUM_PINS-1:0] dac_down_q;
   logic                ref_up_d;
   logic                ref_up_q;
   logic                adc_down_d;
   logic                adc_down_q;

   assign global_down   = power_q[GLOBAL_POWER_DOWN_BIT];
   assign ref_enable    = power_q[REF_ENABLE_BIT];
   assign channel_sleep = power_q[SLEEP_LSB +: NUM_PINS];

   // A channel that is not a DAC ignores its sleep bit; the global bit
   // overrides everything because it also drops the shared reference.
   always_comb begin
      if (global_down) begin
         ref_up_d   = 1'b0;
         dac_down_d = '1;
         adc_down_d = 1'b1;
      end else begin
         ref_up_d   = ref_enable;
         dac_down_d = channel_sleep & dac_mode_mask;
         adc_down_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ref_up_q   <= 1'b0;
         dac_down_q <= '0;
         adc_down_q <= 1'b0;
      end else if (clk_en) begin
         ref_up_q   <= ref_up_d;
         dac_down_q <= dac_down_d;
         adc_down_q <= adc_down_d;
      end
   end

   // Reference, buffer and pin drive move together; an external source
   // on the reference pin is only safe while this stays low.
   assign ref_power_up        = ref_up_q;
   assign ref_buffer_power_up = ref_up_q;
   assign ref_pin_drive       = ref_up_q;
   assign dac_power_down      = dac_down_q;
   assign adc_power_down      = adc_down_q;

   // ------------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------------
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      ppdc_pin_drive u_drive (
         .ref_clk    (ref_clk),
         .reset      (reset),
         .clk_en     (clk_en),
         .out_select (out_sel_q[PIN_LSB + i]),
         .open_drain (open_drain_q[PIN_LSB + i]),
         .high_z     (high_z_q[PIN_LSB + i]),
         .level      (gpio_level[i]),
         .pin_out    (pin_out[i]),
         .pin_oe_n   (pin_oe_n[i])
      );
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   logic [NUM_PINS-1:0] dac_expect;
   assign dac_expect = channel_sleep & dac_mode_mask;

   property p_global_all_down;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && global_down) |=>
         (dac_power_down == '1) && adc_power_down && !ref_power_up
         && !ref_buffer_power_up && !ref_pin_drive;
   endproperty
   a_global_all_down: assert property (p_global_all_down)
      else $error("global power-down left a block powered");

   property p_channel_follow;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && !global_down) |=>
         (dac_power_down == $past(dac_expect)) && !adc_power_down;
   endproperty
   a_channel_follow: assert property (p_channel_follow)
      else $error("DAC power state does not follow channel bits");

   property p_ref_up;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && ref_enable && !global_down) |=>
         ref_power_up && ref_buffer_power_up && ref_pin_drive;
   endproperty
   a_ref_up: assert property (p_ref_up)
      else $error("reference not powered with its enable set");

   property p_ref_down;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && !ref_enable) |=> !ref_power_up && !ref_buffer_power_up;
   endproperty
   a_ref_down: assert property (p_ref_down)
      else $error("reference powered with its enable clear");

   property p_non_dac_awake;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && !global_down) |=>
         ((dac_power_down & ~$past(dac_mode_mask)) == '0);
   endproperty
   a_non_dac_awake: assert property (p_non_dac_awake)
      else $error("non-DAC channel powered down");

   property p_reset_values;
      @(posedge ref_clk) disable iff (reset)
      $fell(reset) |-> (open_drain_q == RST_OPEN_DRAIN)
         && (high_z_q == RST_HIGH_Z) && (pin_oe_n == '1);
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("drive registers not zero after reset");

   // Every read of the power register is watched, not only one that
   // directly follows a write, so the check sees all written patterns.
   property p_reserved_zero;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && reg_rd_en && (reg_addr == ADDR_POWER_REF)) |=>
         reg_rd_valid && ((reg_rdata & ~POWER_WMASK) == READ_ZERO);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits read back non-zero");

   property p_read_answer;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && reg_rd_en && (reg_addr == ADDR_OPEN_DRAIN)) |=>
         reg_rd_valid && (reg_rdata == $past(open_drain_q));
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("open-drain register read wrong");

   c_global_down: cover property (@(posedge ref_clk) disable iff (reset)
      adc_power_down ##1 !adc_power_down);
   c_ref_up: cover property (@(posedge ref_clk) disable iff (reset)
      ref_power_up && (dac_power_down != '0));
   c_read: cover property (@(posedge ref_clk) disable iff (reset)
      reg_rd_valid && (reg_rdata != READ_ZERO));

endmodule // ppdc_config_regs

// [verif/ppdc_host_model.sv]
`timescale 1ns/1ps
module ppdc_host_model (
   // Clock
   input  wire logic                 ref_clk,
   // Register port towards the device
   output logic                      reg_wr_en,
   output logic                      reg_rd_en,
   output ppdc_pkg::ppdc_addr_t      reg_addr,
   output ppdc_pkg::ppdc_word_t      reg_wdata,
   input  wire ppdc_pkg::ppdc_word_t reg_rdata,
   input  wire logic                 reg_rd_valid
);
   import ppdc_pkg::*;

   // ------------------------------------------------------------------
   // Idle bus
   // ------------------------------------------------------------------
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr  = 4'h0;
      reg_wdata = 16'h0000;
   end

   // ------------------------------------------------------------------
   // Accesses
   // ------------------------------------------------------------------
   // Released address and data show the inverse of the last value, so a
   // design that samples them outside its enable cannot pass by luck.
   task automatic wr(input ppdc_addr_t a, input ppdc_word_t d);
      @(posedge ref_clk);
      #1;
      reg_wr_en = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(posedge ref_clk);
      #1;
      reg_wr_en = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask

   // The answer is taken 1 ns after the taking edge.
   task automatic rd(input ppdc_addr_t a, output ppdc_word_t d,
                     output logic ok);
      @(posedge ref_clk);
      #1;
      reg_rd_en = 1'b1;
      reg_addr  = a;
      @(posedge ref_clk);
      #1;
      reg_rd_en = 1'b0;
      reg_addr  = ~a;
      ok        = reg_rd_valid;
      d         = reg_rdata;
   endtask
endmodule // ppdc_host_model

// [verif/ppdc_config_regs_test.sv]
`timescale 1ns/1ps
module ppdc_config_regs_test;
   import ppdc_pkg::*;

   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic        ref_clk;
   logic        reset;
   logic        clk_en;
   logic        reg_wr_en;
   logic        reg_rd_en;
   ppdc_addr_t  reg_addr;
   ppdc_word_t  reg_wdata;
   ppdc_word_t  reg_rdata;
   logic        reg_rd_valid;
   logic [7:0]  dac_mode_mask;
   logic [7:0]  gpio_level;
   logic        ref_power_up;
   logic        ref_buffer_power_up;
   logic        ref_pin_drive;
   logic [7:0]  dac_power_down;
   logic        adc_power_down;
   logic [7:0]  pin_in;
   logic [7:0]  pin_out;
   logic [7:0]  pin_oe_n;
   int          err_total;
   int          checked;
   ppdc_word_t  exp_pins;

   // Pads carry a pull-up: a released pin reads high.
   assign pin_in = pin_oe_n | pin_out;

   ppdc_config_regs #(.NUM_PINS(8)) u_ppdc_config_regs (
      .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
      .dac_mode_mask(dac_mode_mask), .gpio_level(gpio_level),
      .ref_power_up(ref_power_up),
      .ref_buffer_power_up(ref_buffer_power_up),
      .ref_pin_drive(ref_pin_drive), .dac_power_down(dac_power_down),
      .adc_power_down(adc_power_down), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n));

   ppdc_host_model u_ppdc_host_model (
      .ref_clk(ref_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic chk(input string nm, input ppdc_word_t e,
                      input ppdc_word_t g);
      checked++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask

   task automatic rd_chk(input ppdc_addr_t a, input ppdc_word_t e);
      ppdc_word_t d;
      logic       ok;
      u_ppdc_host_model.rd(a, d, ok);
      chk("reg_rd_valid", 16'h0001, {15'h0000, ok});
      chk("reg_rdata", e, d);
   endtask

   // Outputs follow a register one edge after the write edge; settle waits two.
   task automatic settle();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   task automatic pwr_chk(input logic [11:0] e);
      chk("power", {4'h0, e}, {4'h0, ref_power_up, ref_buffer_power_up,
          ref_pin_drive, adc_power_down, dac_power_down});
   endtask

   task automatic reset_chk();
      for (int a = 0; a < 4; a++) begin
         rd_chk(a[3:0], 16'h0000);
      end
      pwr_chk(12'h000);
      chk("pins", 16'hff00, {pin_oe_n, pin_out});
   endtask

   // Expected {oe_n, out}; three-state wins over output select.
   function automatic ppdc_word_t pins_of(input logic [7:0] os, od, hz,
                                          lv);
      ppdc_word_t r;
      r = 16'hff00;
      for (int i = 0; i < 8; i++) begin
         if (!hz[i] && os[i] && od[i]) begin
            r[8+i] = lv[i];
         end else if (!hz[i] && os[i]) begin
            r[8+i] = 1'b0;
            r[i]   = lv[i];
         end
      end
      return r;
   endfunction

   task automatic print_verdict();
      if (err_total == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Clock and watchdog
   // ------------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // The tests need under a hundred cycles; 2000 cycles means a hang.
   initial begin
      #10000;
      err_total++;
      print_verdict();
   end

   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      err_total     = 0;
      checked       = 0;
      reset         = 1'b1;
      clk_en        = 1'b1;
      dac_mode_mask = 8'h0f;
      gpio_level    = 8'h5a;
      repeat (16) @(posedge ref_clk);
      #1;
      reset = 1'b0;
      reset_chk();
      u_ppdc_host_model.wr(ADDR_POWER_REF, 16'hffff);
      settle();
      pwr_chk({3'b000, 1'b1, 8'hff});
      rd_chk(ADDR_POWER_REF, 16'h06ff);
      u_ppdc_host_model.wr(ADDR_POWER_REF, 16'h02a5);
      settle();
      pwr_chk({3'b111, 1'b0, 8'h05});
      dac_mode_mask = 8'hf0;
      // Internal reference is dropped before any external source is used.
      u_ppdc_host_model.wr(ADDR_POWER_REF, 16'h00ff);
      settle();
      pwr_chk({3'b000, 1'b0, 8'hf0});
      for (int a = 1; a < 4; a++) begin
         u_ppdc_host_model.wr(a[3:0], 16'hffff);
         rd_chk(a[3:0], 16'h00ff);
      end
      u_ppdc_host_model.wr(4'h7, 16'hffff);
      rd_chk(4'h7, 16'h0000);
      // A write offered while the clock enable is low is not taken.
      clk_en = 1'b0;
      u_ppdc_host_model.wr(ADDR_OPEN_DRAIN, 16'h0000);
      clk_en = 1'b1;
      rd_chk(ADDR_OPEN_DRAIN, 16'h00ff);
      // Output select goes first, then the drive choice.
      u_ppdc_host_model.wr(ADDR_OUT_SELECT, 16'h007f);
      u_ppdc_host_model.wr(ADDR_OPEN_DRAIN, 16'h00f0);
      u_ppdc_host_model.wr(ADDR_HIGH_Z, 16'h0003);
      for (int k = 0; k < 2; k++) begin
         gpio_level = (k == 0) ? 8'h5a : 8'ha5;
         settle();
         exp_pins = pins_of(8'h7f, 8'hf0, 8'h03, gpio_level);
         chk("pins", exp_pins,
             {pin_oe_n, pin_out});
         repeat (3) @(posedge ref_clk);
         #1;
         rd_chk(ADDR_PIN_LEVEL,
                {8'h00, exp_pins[15:8] | exp_pins[7:0]});
      end
      // A second reset in mid-run brings every register back.
      reset = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      reset = 1'b0;
      reset_chk();
      print_verdict();
   end
endmodule // ppdc_config_regs_test
